// >>> uwd_pkg.sv
package uwd_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRLA    = 8'h00;
    localparam logic [7:0] OFF_CTRLB    = 8'h04;
    localparam logic [7:0] OFF_IRQ_ENABLE_CLEAR_REG = 8'h14;
    localparam logic [7:0] OFF_IRQ_ENABLE_SET_REG = 8'h16;
    localparam logic [7:0] OFF_FLAG     = 8'h18;
    localparam logic [7:0] OFF_STATUS   = 8'h1A;
    localparam logic [7:0] OFF_SYNCBUSY = 8'h1C;
    localparam logic [7:0] OFF_DATA     = 8'h28;
    localparam logic [7:0] OFF_SLEEP    = 8'h30;
    // CTRLA fields
    localparam int A_SOFT_RESET_BIT    = 0;
    localparam int A_ENABLE   = 1;
    localparam int A_RUN_IN_STANDBY = 7;
    localparam int A_TRANSMIT_PIN_SELECT     = 16;
    localparam int A_RECEIVE_PIN_SELECT     = 20;
    localparam int A_SAMPLE_WINDOW_ADJUST    = 22;
    localparam int A_COMM_MODE_SELECT    = 28;
    // CTRLB fields
    localparam int B_FRAME_START_DETECT_ENABLE = 9;
    localparam int B_TRANSMITTER_ENABLE = 16;
    localparam int B_RECEIVER_ENABLE = 17;
    // Flag bit positions
    localparam int F_DRE   = 0;
    localparam int F_TXC   = 1;
    localparam int F_RXC   = 2;
    localparam int F_RXS   = 3;
    localparam int F_CLEAR_TO_SEND_CHANGE_FLAG = 4;
    localparam int F_BREAK_RECEIVED_FLAG = 5;
    localparam int F_ERROR = 7;
    // Status bit positions
    localparam int S_PARITY_ERROR = 0;
    localparam int S_FRAMING_ERROR = 1;
    // Reset values
    localparam logic [31:0] CTRLA_RST = 32'h0000_0000;
    localparam logic [31:0] CTRLB_RST = 32'h0000_0000;
    localparam logic [7:0]  INTEN_RST = 8'h00;
    // Sample window middles
    localparam logic [3:0] MID16 = 4'h8;
    localparam logic [3:0] MID8  = 4'h4;
    // Write synchronizer depth
    localparam int SYNC_STAGES = 2;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : uwd_pkg

// >>> uwd_rxmem.sv
`timescale 1ns/1ps
module uwd_rxmem #(
    parameter int DEPTH = 4,
    parameter int WIDTH = 9
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             ce,
    input  wire logic             wr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic             rd,
    output logic      [WIDTH-1:0] rdata,
    output logic                  avail,
    output logic                  full
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_r;
    logic [AW:0]      rp_r;
    wire              do_wr = wr && !full;
    wire              do_rd = rd && avail;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be power of two >= 2");
    end

    assign avail = wp_r != rp_r;
    assign full  = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);

    always_ff @(posedge aclk) begin
        if (ce && do_wr) begin
            mem[wp_r[AW-1:0]] <= wdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_r  <= '0;
            rp_r  <= '0;
            rdata <= '0;
        end else if (ce) begin
            if (do_wr) wp_r <= wp_r + 1'b1;
            if (do_rd) rp_r <= rp_r + 1'b1;
            rdata <= mem[rp_r[AW-1:0] + (do_rd ? 1'b1 : 1'b0)];
        end
    end
endmodule : uwd_rxmem

// >>> uwd_aux.sv
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module uwd_aux #(
    parameter int RX_DEPTH = 4
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        rxd_pad,
    input  wire logic        txd_core,
    output logic             txd_pad,
    output logic             txd_pad_oe_n,
    input  wire logic        rx_sample_tick,
    input  wire logic        rx_bit_start,
    input  wire logic        rx_byte_valid,
    input  wire logic [8:0]  rx_byte,
    input  wire logic        tx_busy,
    input  wire logic        tx_complete_evt,
    input  wire logic        cts_change_evt,
    input  wire logic        break_evt,
    input  wire logic        framing_error,
    input  wire logic        parity_error,
    input  wire logic        other_error_evt,
    input  wire logic        oversample_8x,
    input  wire logic        sleep_req,
    input  wire logic        external_clocking,
    output logic             rx_line,
    output logic             rx_bit_value,
    output logic [8:0]       tx_data,
    output logic             tx_load,
    output logic             osc_request,
    output logic             core_clock_enable,
    output logic             core_soft_reset,
    output logic             core_enable,
    output logic             core_rx_enable,
    output logic             core_tx_enable,
    output logic             dma_rx_req,
    output logic             dma_tx_req,
    output logic             irq,
    output logic             wake
);
    import uwd_pkg::*;

    initial begin
        if (RX_DEPTH < 2) $error("RX_DEPTH too small");
    end

    logic [31:0] ctrla_r, ctrlb_r;
    logic [7:0]  inten_r, flag_r, flag_nxt, status_r;
    logic [8:0]  txbuf_r;
    logic        txfull_r, rxd_q_r, frame_r;
    logic [3:0]  samp_cnt_r;
    logic [2:0]  votes_r;
    logic [SYNC_STAGES-1:0] s_soft_reset_bit_r, s_en_r, s_receiver_enable_r, s_transmitter_enable_r;
    logic        aw_ok_r, w_ok_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        rx_rd;
    logic [8:0]  rx_q;
    logic        rx_avail, rx_full;

    // Write path: capture address and data in either order
    wire do_wr = aw_ok_r && w_ok_r && !s_axi_bvalid;
    wire [7:0] wa = awaddr_r;
    wire wr_ctrla = do_wr && wa == OFF_CTRLA;
    wire wr_ctrlb = do_wr && wa == OFF_CTRLB;
    wire wr_enclr = do_wr && wa == (OFF_IRQ_ENABLE_CLEAR_REG & 8'hFC) && wstrb_r[0];
    wire wr_enset = do_wr && wa == (OFF_IRQ_ENABLE_SET_REG & 8'hFC) && wstrb_r[2];
    wire wr_flag  = do_wr && wa == OFF_FLAG && wstrb_r[0];
    wire wr_data  = do_wr && wa == OFF_DATA;
    wire wr_known = wa == OFF_CTRLA || wa == OFF_CTRLB || wa == OFF_FLAG || wa == OFF_DATA
                    || wa == (OFF_IRQ_ENABLE_CLEAR_REG & 8'hFC) || wa == OFF_SLEEP;
    wire [7:0] clr_bits = wdata_r[7:0];
    wire [7:0] set_bits = wdata_r[23:16];

    assign s_axi_awready = !aw_ok_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_ok_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        for (int i = 0; i < 4; i++) begin
            if (st[i]) old[i*8 +: 8] = nw[i*8 +: 8];
        end
        return old;
    endfunction : merge

    function automatic logic maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
    endfunction : maj3

    // Loop-back through the pad when pin selections match
    wire loopback = ctrla_r[A_RECEIVE_PIN_SELECT +: 2] == ctrla_r[A_TRANSMIT_PIN_SELECT +: 2];
    assign txd_pad      = txd_core;
    assign txd_pad_oe_n = !core_tx_enable;
    assign rx_line      = (loopback && core_tx_enable) ? txd_core : rxd_pad;

    // Sleep policy
    wire run_in_standby = ctrla_r[A_RUN_IN_STANDBY];
    wire busy     = tx_busy || frame_r;
    wire clk_off  = sleep_req && !run_in_standby && !busy;
    wire drop_rx  = sleep_req && !run_in_standby && external_clocking && !frame_r;
    wire fall     = rxd_q_r && !rx_line;
    wire sof      = ctrlb_r[B_FRAME_START_DETECT_ENABLE] && fall && core_rx_enable;
    assign osc_request       = frame_r || sof || !clk_off;
    assign core_clock_enable = osc_request && !(drop_rx && !sof);

    // Sample window: three samples about the middle, shifted by adjust
    wire [3:0] mid = (oversample_8x ? MID8 : MID16) + {2'b00, ctrla_r[A_SAMPLE_WINDOW_ADJUST +: 2]};
    wire in_win = samp_cnt_r == mid - 4'h1 || samp_cnt_r == mid || samp_cnt_r == mid + 4'h1;
    assign rx_bit_value = ctrla_r[A_COMM_MODE_SELECT] ? rx_line : maj3(votes_r);

    // Flags
    wire rx_push = rx_byte_valid && core_rx_enable && !drop_rx;
    wire rx_read = s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_DATA;
    assign rx_rd = rx_read;
    always_comb begin
        flag_nxt = flag_r;
        if (wr_flag) flag_nxt = flag_r & ~clr_bits;
        flag_nxt[F_DRE] = !txfull_r;
        flag_nxt[F_RXC] = rx_avail;
        if (tx_complete_evt) flag_nxt[F_TXC] = 1'b1;
        if (sof && !drop_rx) flag_nxt[F_RXS] = 1'b1;
        if (cts_change_evt) flag_nxt[F_CLEAR_TO_SEND_CHANGE_FLAG] = 1'b1;
        if (break_evt) flag_nxt[F_BREAK_RECEIVED_FLAG] = 1'b1;
        if (framing_error || parity_error || other_error_evt) flag_nxt[F_ERROR] = 1'b1;
        flag_nxt[6] = 1'b0;
    end

    // Request is pure combination of flag and enable, no clock needed
    wire [7:0] pend = flag_r & inten_r;
    assign irq = |pend;
    wire err_wakes = pend[F_ERROR] && status_r[7:2] != 6'h00;
    wire [7:0] wake_set = run_in_standby ? (pend & ~(8'h01 << F_ERROR)) : (pend & 8'h0C);
    assign wake = |wake_set || (run_in_standby && err_wakes);

    assign dma_rx_req = rx_avail;
    assign dma_tx_req = !txfull_r && core_tx_enable;

    assign core_soft_reset = s_soft_reset_bit_r[SYNC_STAGES-1];
    assign core_enable     = s_en_r[SYNC_STAGES-1];
    assign core_rx_enable  = s_receiver_enable_r[SYNC_STAGES-1];
    assign core_tx_enable  = s_transmitter_enable_r[SYNC_STAGES-1];
    wire [2:0] sync_busy = {ctrlb_r[B_RECEIVER_ENABLE] != core_rx_enable || ctrlb_r[B_TRANSMITTER_ENABLE] != core_tx_enable,
                            ctrla_r[A_ENABLE] != core_enable, ctrla_r[A_SOFT_RESET_BIT] != core_soft_reset};

    wire [31:0] rd_mux =
        s_axi_araddr == OFF_CTRLA ? ctrla_r :
        s_axi_araddr == OFF_CTRLB ? ctrlb_r :
        s_axi_araddr == (OFF_IRQ_ENABLE_CLEAR_REG & 8'hFC) ? {8'h00, inten_r, 8'h00, inten_r} :
        s_axi_araddr == OFF_FLAG ? {8'h00, status_r, 8'h00, flag_r} :
        s_axi_araddr == OFF_SYNCBUSY ? {29'h0, sync_busy} :
        s_axi_araddr == OFF_DATA ? {23'h0, rx_q} :
        s_axi_araddr == OFF_SLEEP ? {29'h0, wake, irq, core_clock_enable} : 32'h0000_0000;
    wire rd_known = s_axi_araddr == OFF_CTRLA || s_axi_araddr == OFF_CTRLB || s_axi_araddr == OFF_FLAG
                    || s_axi_araddr == (OFF_IRQ_ENABLE_CLEAR_REG & 8'hFC) || s_axi_araddr == OFF_SYNCBUSY
                    || s_axi_araddr == OFF_DATA || s_axi_araddr == OFF_SLEEP;

    uwd_rxmem #(.DEPTH(RX_DEPTH), .WIDTH(9)) u_rxmem (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .wr      (rx_push),
        .wdata   (rx_byte),
        .rd      (rx_rd),
        .rdata   (rx_q),
        .avail   (rx_avail),
        .full    (rx_full)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok_r <= 1'b0;
            w_ok_r  <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_r  <= 1'b1;
                awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_r  <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_ok_r <= 1'b0;
                w_ok_r  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || core_soft_reset) begin
            ctrla_r  <= CTRLA_RST;
            ctrlb_r  <= CTRLB_RST;
            inten_r  <= INTEN_RST;
            flag_r   <= 8'h01;
            status_r <= 8'h00;
            txbuf_r  <= 9'h000;
            txfull_r <= 1'b0;
            tx_load  <= 1'b0;
            tx_data  <= 9'h000;
        end else if (ce) begin
            if (wr_ctrla) ctrla_r <= merge(ctrla_r, wdata_r, wstrb_r);
            if (wr_ctrlb) ctrlb_r <= merge(ctrlb_r, wdata_r, wstrb_r);
            inten_r  <= (inten_r | (wr_enset ? set_bits : 8'h00)) & ~(wr_enclr ? clr_bits : 8'h00);
            flag_r   <= flag_nxt;
            status_r <= (wr_flag ? (status_r & ~wdata_r[23:16]) : status_r)
                        | {5'h00, other_error_evt, framing_error, parity_error};
            tx_load  <= 1'b0;
            if (wr_data) begin
                txbuf_r  <= wdata_r[8:0];
                txfull_r <= 1'b1;
            end else if (txfull_r && !tx_busy && core_tx_enable) begin
                tx_data  <= txbuf_r;
                tx_load  <= 1'b1;
                txfull_r <= 1'b0;
            end
        end
    end

    // Control bits cross into the core domain through a flop chain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_soft_reset_bit_r <= '0;
            s_en_r    <= '0;
            s_receiver_enable_r  <= '0;
            s_transmitter_enable_r  <= '0;
        end else if (ce) begin
            s_soft_reset_bit_r <= {s_soft_reset_bit_r[SYNC_STAGES-2:0], ctrla_r[A_SOFT_RESET_BIT]};
            s_en_r    <= {s_en_r[SYNC_STAGES-2:0], ctrla_r[A_ENABLE]};
            s_receiver_enable_r  <= {s_receiver_enable_r[SYNC_STAGES-2:0], ctrlb_r[B_RECEIVER_ENABLE] && ctrla_r[A_ENABLE]};
            s_transmitter_enable_r  <= {s_transmitter_enable_r[SYNC_STAGES-2:0], ctrlb_r[B_TRANSMITTER_ENABLE] && ctrla_r[A_ENABLE]};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rxd_q_r    <= 1'b1;
            frame_r    <= 1'b0;
            samp_cnt_r <= 4'h0;
            votes_r    <= 3'h0;
        end else if (ce) begin
            rxd_q_r <= rx_line;
            if (sof) frame_r <= 1'b1;
            else if (rx_byte_valid) frame_r <= 1'b0;
            if (rx_bit_start) samp_cnt_r <= 4'h0;
            else if (rx_sample_tick) samp_cnt_r <= samp_cnt_r + 4'h1;
            if (rx_sample_tick && in_win) votes_r <= {votes_r[1:0], rx_line};
        end
    end
endmodule : uwd_aux

// >>> uwd_aux_properties.sv
`timescale 1ns/1ps
module uwd_aux_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        txd_core,
    input wire logic        txd_pad,
    input wire logic        txd_pad_oe_n,
    input wire logic        core_tx_enable,
    input wire logic        core_rx_enable,
    input wire logic        rx_byte_valid,
    input wire logic        sleep_req,
    input wire logic        dma_rx_req
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready && ce;
    endsequence
    a_pad_follow: assert property (txd_pad == txd_core)
        else $error("pad differs from transmitter");
    a_oe_level: assert property (txd_pad_oe_n == !core_tx_enable)
        else $error("pad enable wrong");
    a_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read not answered");
    a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_rx_push: assert property (rx_byte_valid && ce && core_rx_enable && !sleep_req |=> dma_rx_req)
        else $error("no receive request after character");
endmodule : uwd_aux_props

// >>> uwd_remote_node.sv
`timescale 1ns/1ps
module uwd_remote_node #(
    parameter int         BITC = 16,
    parameter logic [7:0] BYTE = 8'h5A
) (
    input  wire logic aclk,
    input  wire logic go,
    output logic      rxd
);
    logic [9:0] sh_r = 10'h3FF;
    int         k_r  = 0;
    // Line idles high like a pulled-up wire between frames
    assign rxd = (k_r > 0) ? sh_r[0] : 1'h1;
    always @(posedge aclk) begin
        if (go) begin
            sh_r <= {1'h1, BYTE, 1'h0};
            k_r  <= 10 * BITC;
        end else if (k_r > 0) begin
            k_r <= k_r - 1;
            if (k_r % BITC == 1)
                sh_r <= {1'h1, sh_r[9:1]};
        end
    end
endmodule : uwd_remote_node

// >>> uwd_aux_tb.sv
`timescale 1ns/1ps
module uwd_aux_tb;
    import uwd_pkg::*;
    logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rxd_pad, txd_core;
    logic        txd_pad, txd_pad_oe_n, rx_sample_tick, rx_bit_start, rx_byte_valid, tx_busy, tx_complete_evt;
    logic        cts_change_evt, break_evt, framing_error, parity_error, other_error_evt, oversample_8x;
    logic        sleep_req, external_clocking, rx_line, rx_bit_value, tx_load, osc_request, core_clock_enable;
    logic        core_soft_reset, core_enable, core_rx_enable, core_tx_enable, dma_rx_req, dma_tx_req, irq, wake;
    logic        go;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp_v;
    logic [8:0]  rx_byte, tx_data;
    logic [5:0]  ev;
    int          errors = 0, checks_done = 0;
    int          fbit [6] = '{F_TXC, F_CLEAR_TO_SEND_CHANGE_FLAG, F_BREAK_RECEIVED_FLAG, F_ERROR, F_ERROR, F_ERROR};

    assign {other_error_evt, parity_error, framing_error, break_evt, cts_change_evt, tx_complete_evt} = ev;
    uwd_aux #(.RX_DEPTH(4)) uwd_aux_i (.*);
    uwd_remote_node #(.BITC(16), .BYTE(8'h5A)) uwd_remote_node_i (.aclk(aclk), .go(go), .rxd(rxd_pad));

    always #20 aclk = ~aclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    // Handshakes judged mid-cycle, acted on at the following rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, bd;
        int   n;
        bd = 1'h0;
        n  = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        while (!bd && n < 200) begin
            @(negedge aclk);
            ta     = s_axi_awvalid && s_axi_awready;
            tw     = s_axi_wvalid && s_axi_wready;
            bd     = s_axi_bvalid;
            resp_v = s_axi_bresp;
            @(posedge aclk);
            n++;
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
        end
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic ta, rv;
        int   n;
        rv = 1'h0;
        n  = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        while (!rv && n < 200) begin
            @(negedge aclk);
            ta     = s_axi_arvalid && s_axi_arready;
            rv     = s_axi_rvalid;
            rd_v   = s_axi_rdata;
            resp_v = s_axi_rresp;
            @(posedge aclk);
            n++;
            if (ta) s_axi_arvalid <= 1'h0;
        end
        @(posedge aclk);
    endtask : rd

    task automatic tally_and_finish();
        if (errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (6000) @(posedge aclk);
        errors++;
        tally_and_finish();
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rx_sample_tick,
         rx_bit_start, rx_byte_valid, tx_busy, oversample_8x, sleep_req, external_clocking, go, ev,
         s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_byte} = '0;
        aclk = 1'h0;
        ce = 1'h1;
        txd_core = 1'h1;
        s_axi_wstrb = 4'hF;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        s_axi_bready <= 1'h1;
        s_axi_rready <= 1'h1;
        @(posedge aclk);
        rd(OFF_CTRLA);
        chk(rd_v, CTRLA_RST);
        rd(OFF_FLAG);
        chk(rd_v[7:0], 8'h01);
        rd(8'h3C);
        chk(resp_v, RESP_SLVERR);
        chk(rd_v, 32'h0);
        wr(OFF_IRQ_ENABLE_CLEAR_REG, 32'h00BA_0000);
        wr(OFF_IRQ_ENABLE_CLEAR_REG, 32'h0000_0008);
        rd(OFF_IRQ_ENABLE_CLEAR_REG);
        chk(rd_v & 32'h00FF_00FF, 32'h00B2_00B2);
        wr(OFF_IRQ_ENABLE_CLEAR_REG, 32'h0008_0000);
        wr(OFF_CTRLA, 32'h0000_0082);
        wr(OFF_CTRLB, 32'h0003_0000);
        repeat (4) @(posedge aclk);
        chk(core_enable, 1'h1);
        chk(core_tx_enable, 1'h1);
        chk(core_rx_enable, 1'h1);
        txd_core <= 1'h0;
        @(posedge aclk);
        chk(rx_line, 1'h0);
        sleep_req <= 1'h1;
        // The other error comes after framing and parity so a stale non-frame error cannot mask the frame/parity case
        for (int i = 0; i < 6; i++) begin
            ev <= 6'h01 << i;
            @(posedge aclk);
            ev <= '0;
            @(posedge aclk);
            chk(irq, 1'h1);
            chk(wake, i < 3 || i == 5);
            rd(OFF_FLAG);
            chk(rd_v[fbit[i]], 1'h1);
            wr(OFF_FLAG, 32'h0);
            chk(irq, 1'h1);
            wr(OFF_FLAG, 32'h1 << fbit[i]);
            chk(irq, 1'h0);
        end
        s_axi_wstrb <= 4'h4;
        wr(OFF_CTRLA, 32'hFF10_FFFF);
        s_axi_wstrb <= 4'hF;
        rd(OFF_CTRLA);
        chk(rd_v, 32'h0010_0082);
        chk(rx_line, 1'h1);
        wr(OFF_CTRLA, 32'h0010_0002);
        wr(OFF_CTRLB, 32'h0003_0200);
        repeat (4) @(posedge aclk);
        chk(core_clock_enable, 1'h0);
        go <= 1'h1;
        @(posedge aclk);
        go <= 1'h0;
        repeat (4) @(posedge aclk);
        chk(osc_request, 1'h1);
        chk(core_clock_enable, 1'h1);
        chk(irq, 1'h1);
        chk(wake, 1'h1);
        rd(OFF_FLAG);
        chk(rd_v[F_RXS], 1'h1);
        wr(OFF_FLAG, 32'h08);
        repeat (170) @(posedge aclk);
        sleep_req <= 1'h0;
        tx_busy <= 1'h1;
        @(posedge aclk);
        chk(dma_tx_req, 1'h1);
        wr(OFF_DATA, 32'h155);
        chk(dma_tx_req, 1'h0);
        tx_busy <= 1'h0;
        repeat (4) @(posedge aclk);
        chk(dma_tx_req, 1'h1);
        chk(tx_data, 9'h155);
        rx_byte <= 9'h0C3;
        rx_byte_valid <= 1'h1;
        @(posedge aclk);
        rx_byte_valid <= 1'h0;
        @(posedge aclk);
        chk(dma_rx_req, 1'h1);
        rd(OFF_DATA);
        chk(rd_v, 32'h0C3);
        chk(dma_rx_req, 1'h0);
        tally_and_finish();
    end
endmodule : uwd_aux_tb

bind uwd_aux uwd_aux_props uwd_aux_props_i (.*);
